// [logic/oct_pkg.sv]
package oct_pkg;
  // ----------------------------------------------------------------
  // Message codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_CONNECT = 8'h06;
  localparam logic [7:0] CODE_DISCONNECT = 8'h07;
  localparam logic [7:0] CODE_KEYBOARD = 8'h08;
  localparam logic [7:0] CODE_SYS_LOOP = 8'h09;
  localparam logic [7:0] CODE_ELEM_LOOP = 8'h0a;
  localparam logic [7:0] CODE_CONN_RESP = 8'h86;
  localparam logic [7:0] CODE_SCREEN = 8'h88;
  localparam logic [7:0] CODE_MAINT_STAT = 8'h89;
  // ----------------------------------------------------------------
  // Field values and positions
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT_CONNECTED = 8'h01;
  localparam logic [7:0] STAT_NO_CONNECT = 8'h00;
  localparam logic [7:0] ADDR_BROADCAST = 8'h00;
  localparam logic [7:0] ADDR_NET_END = 8'h01;
  localparam logic [7:0] ADDR_CUST_END = 8'h02;
  localparam logic [7:0] REP_ADDR_OFFSET = 8'h02;
  localparam int KBD_MAX = 8;
  localparam int SCR_MAX = 24;
  localparam int SYS_LEN = 11;
  localparam int CMD_CLEAR = 6;
  localparam int CMD_SP_ON = 5;
  localparam int CMD_SP_OFF = 4;
  localparam int CMD_NET_ON = 3;
  localparam int CMD_CUST_ON = 2;
  localparam int CMD_NET_OFF = 1;
  localparam int CMD_CUST_OFF = 0;
  localparam int ST_PROP = 6;
  localparam int ST_SPECIAL = 5;
  localparam int ST_CUST = 4;
  localparam int ST_NET = 3;
  localparam int ST_LOCAL_PWR = 2;
  localparam int ST_CREV = 1;
  localparam int ST_NREV = 0;
  // Unit roles
  typedef enum logic [1:0] {
    OCT_NET_END = 2'b00,
    OCT_CUST_END = 2'b01,
    OCT_REPEATER = 2'b11
  } oct_role_e;
endpackage

// [logic/oct_link_if.sv]
`timescale 1ns/1ps
// Octet stream in each direction; each octet is one valid cycle, sof marks code octet.
interface oct_link_if;
  logic [7:0] d2p_data;
  logic d2p_valid;
  logic d2p_sof;
  logic d2p_eof;
  logic [7:0] d2p_addr;
  logic [7:0] p2d_data;
  logic p2d_valid;
  logic p2d_sof;
  logic p2d_eof;
  logic [7:0] p2d_addr;
  modport dev (output d2p_data, d2p_valid, d2p_sof, d2p_eof, d2p_addr,
               input p2d_data, p2d_valid, p2d_sof, p2d_eof, p2d_addr);
  modport peer (input d2p_data, d2p_valid, d2p_sof, d2p_eof, d2p_addr,
                output p2d_data, p2d_valid, p2d_sof, p2d_eof, p2d_addr);
endinterface

// [logic/oct_dev.sv]
// Summary of operation
// - Requester waits for connected response first
// - Session open until disconnect or timeout
// - Network end holds at least one session
// - Unsupported units may drop or refuse connect
// - No room: answer no-connect status
// - Accept: response, then current screen
// - Connect response: code 134, status octet
// - Keyboard and screen only in session
// - Keyboard carries one to eight octets
// - Screen carries one to twenty-four octets
// - Network end system loopback is broadcast
// - Customer end system loopback to network end
// - Receivers execute own octet, send status
// - System loopback octet layout per element
// - Repeater number is address minus two
// - Customer end uses element loopback offline
// - Command octet bit meanings
// - Zero command octet is a poll
// - Element loopback acted on by addressee
// - Status octet maintenance bits
// - Power and pair reversal status bits
// - Special loopback only at customer end
// - Active condition answers poll with status
`timescale 1ns/1ps
module oct_dev #(
  parameter oct_pkg::oct_role_e ROLE = oct_pkg::OCT_NET_END,
  parameter int SESSIONS = 1,
  parameter int TIMEOUT_CYC = 0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Identity and straps
  input wire logic [7:0] own_addr,
  input wire logic local_pwr,
  input wire logic cust_rev,
  input wire logic net_rev,
  input wire logic prop_state,
  input wire logic net_end_online,
  input wire logic term_support,
  // Screen source: terminal logic supplies current screen octets
  input wire logic [7:0] scr_data,
  input wire logic scr_valid,
  input wire logic scr_last,
  output logic scr_ready,
  output logic scr_first,
  // Keyboard sink and loopback outputs
  output logic [7:0] kbd_data,
  output logic kbd_valid,
  output logic session_open,
  output logic loop_net,
  output logic loop_cust,
  output logic loop_special,
  oct_link_if.dev lnk
);
  initial begin
    if (SESSIONS < 0 || SESSIONS > 1) $error("SESSIONS must be 0 or 1");
    if (TIMEOUT_CYC < 0) $error("TIMEOUT_CYC must not be negative");
  end
  // ----------------------------------------------------------------
  // Receive parser
  // ----------------------------------------------------------------
  logic [7:0] rx_code_r;
  logic [4:0] rx_idx_r;
  logic mine_r;
  logic [7:0] cmd_r;
  logic cmd_seen_r;
  logic [7:0] rep_idx;
  logic addr_ok;
  assign rep_idx = own_addr - oct_pkg::REP_ADDR_OFFSET;
  assign addr_ok = (lnk.p2d_addr == own_addr) || (lnk.p2d_addr == oct_pkg::ADDR_BROADCAST);
  logic [4:0] own_idx;
  logic own_oct;
  // Index of our octet in a system loopback, 0 when none; a repeater beyond eight has none
  assign own_idx = (ROLE == oct_pkg::OCT_NET_END) ? 5'h01 :
                   (ROLE == oct_pkg::OCT_CUST_END) ? 5'h02 :
                   (rep_idx >= 8'h01 && rep_idx <= 8'h08) ? 5'(rep_idx + 8'h02) : 5'h00;
  // Our command octet as it arrives, so a command in the last octet acts at eof
  assign own_oct = lnk.p2d_valid && !lnk.p2d_sof && mine_r &&
                   ((rx_code_r == oct_pkg::CODE_ELEM_LOOP && rx_idx_r == 5'h01) ||
                    (rx_code_r == oct_pkg::CODE_SYS_LOOP && rx_idx_r == own_idx));
  // Octet index and code capture
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_code_r <= 8'h00;
      rx_idx_r <= 5'h00;
    end else if (lnk.p2d_valid) begin
      if (lnk.p2d_sof) begin
        rx_code_r <= lnk.p2d_data;
        rx_idx_r <= 5'h01;
      end else if (rx_idx_r != 5'h1f) begin
        rx_idx_r <= rx_idx_r + 5'h01;
      end
    end
  end
  // Pick our own command octet out of the message
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r <= 8'h00;
      cmd_seen_r <= 1'b0;
      mine_r <= 1'b0;
    end else if (lnk.p2d_valid) begin
      if (lnk.p2d_sof) begin
        cmd_seen_r <= 1'b0;
        mine_r <= addr_ok;
      end else if (own_oct) begin
        cmd_r <= lnk.p2d_data;
        cmd_seen_r <= 1'b1;
      end
    end
  end
  // End-of-message events, plus a per-octet keyboard strobe
  logic eom;
  logic is_conn;
  logic is_disc;
  logic is_loop;
  logic is_kbd;
  assign eom = lnk.p2d_valid && lnk.p2d_eof && (lnk.p2d_sof ? addr_ok : mine_r);
  assign is_conn = eom && lnk.p2d_sof && lnk.p2d_data == oct_pkg::CODE_CONNECT;
  assign is_disc = eom && lnk.p2d_sof && lnk.p2d_data == oct_pkg::CODE_DISCONNECT;
  assign is_loop = eom && !lnk.p2d_sof && (rx_code_r == oct_pkg::CODE_ELEM_LOOP ||
                   rx_code_r == oct_pkg::CODE_SYS_LOOP);
  assign is_kbd = lnk.p2d_valid && !lnk.p2d_sof && mine_r &&
                  rx_code_r == oct_pkg::CODE_KEYBOARD && rx_idx_r <= 5'(oct_pkg::KBD_MAX);
  // ----------------------------------------------------------------
  // Session state
  // ----------------------------------------------------------------
  logic [31:0] idle_r;
  logic timed_out;
  assign timed_out = (TIMEOUT_CYC > 0) && (idle_r >= 32'(TIMEOUT_CYC));
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      session_open <= 1'b0;
    end else if (is_conn && SESSIONS > 0 && term_support) begin
      session_open <= 1'b1;
    end else if (is_disc || timed_out) begin
      session_open <= 1'b0;
    end
  end
  // Idle counter for optional timeout
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) idle_r <= 32'h0;
    else if (!session_open || lnk.p2d_valid) idle_r <= 32'h0;
    else if (!timed_out) idle_r <= idle_r + 32'h1;
  end
  // Keyboard octets pass only inside a session
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      kbd_data <= 8'h00;
      kbd_valid <= 1'b0;
    end else begin
      kbd_valid <= is_kbd && session_open;
      kbd_data <= lnk.p2d_data;
    end
  end
  // ----------------------------------------------------------------
  // Loopback states
  // ----------------------------------------------------------------
  logic [7:0] cmd;
  logic cmd_ok;
  // Bypass the register: an element command is the last octet, seen at eof itself
  assign cmd = (own_oct ? lnk.p2d_data : cmd_r) & 8'h7f;
  assign cmd_ok = own_oct || cmd_seen_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      loop_net <= 1'b0;
      loop_cust <= 1'b0;
      loop_special <= 1'b0;
    end else if (is_loop && cmd_ok) begin
      if (cmd[oct_pkg::CMD_CLEAR]) begin
        loop_net <= 1'b0;
        loop_cust <= 1'b0;
        loop_special <= 1'b0;
      end else begin
        if (cmd[oct_pkg::CMD_NET_ON]) loop_net <= 1'b1;
        else if (cmd[oct_pkg::CMD_NET_OFF]) loop_net <= 1'b0;
        if (cmd[oct_pkg::CMD_CUST_ON]) loop_cust <= 1'b1;
        else if (cmd[oct_pkg::CMD_CUST_OFF]) loop_cust <= 1'b0;
        if (ROLE == oct_pkg::OCT_CUST_END) begin
          if (cmd[oct_pkg::CMD_SP_ON]) loop_special <= 1'b1;
          else if (cmd[oct_pkg::CMD_SP_OFF]) loop_special <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_CODE = 3'b001,
    TX_ARG = 3'b011,
    TX_SCODE = 3'b010,
    TX_SDATA = 3'b110
  } oct_tx_e;
  oct_tx_e tx_r;
  logic [7:0] tcode_r;
  logic [7:0] targ_r;
  logic [7:0] reply_addr_r;
  logic scr_pend_r;
  logic [4:0] scnt_r;
  logic [7:0] mstat;
  assign mstat = {1'b0, prop_state, loop_special, loop_cust, loop_net,
                  local_pwr, cust_rev, net_rev};
  assign scr_ready = (tx_r == TX_SDATA) && session_open;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_r <= TX_IDLE;
      tcode_r <= 8'h00;
      targ_r <= 8'h00;
      reply_addr_r <= 8'h00;
      scr_pend_r <= 1'b0;
      scnt_r <= 5'h00;
      scr_first <= 1'b0;
    end else begin
      scr_first <= 1'b0;
      unique case (tx_r)
        TX_IDLE: begin
          if (is_conn && (term_support || ROLE == oct_pkg::OCT_NET_END)) begin
            tcode_r <= oct_pkg::CODE_CONN_RESP;
            targ_r <= (SESSIONS > 0 && term_support) ? oct_pkg::STAT_CONNECTED
                                                     : oct_pkg::STAT_NO_CONNECT;
            scr_pend_r <= SESSIONS > 0 && term_support;
            scr_first <= SESSIONS > 0 && term_support && !session_open;
            reply_addr_r <= lnk.p2d_addr == oct_pkg::ADDR_BROADCAST ? oct_pkg::ADDR_NET_END
                                                                    : lnk.p2d_addr;
            tx_r <= TX_CODE;
          end else if (is_loop && cmd_ok) begin
            tcode_r <= oct_pkg::CODE_MAINT_STAT;
            targ_r <= 8'h00;
            scr_pend_r <= 1'b0;
            reply_addr_r <= oct_pkg::ADDR_NET_END;
            tx_r <= TX_CODE;
          end else if (session_open && scr_valid) begin
            tx_r <= TX_SCODE;
          end
        end
        TX_CODE: tx_r <= TX_ARG;
        TX_ARG: tx_r <= scr_pend_r ? TX_SCODE : TX_IDLE;
        TX_SCODE: begin
          scr_pend_r <= 1'b0;
          scnt_r <= 5'h00;
          tx_r <= TX_SDATA;
        end
        TX_SDATA: begin
          if (!session_open) tx_r <= TX_IDLE;
          else if (scr_valid) begin
            scnt_r <= scnt_r + 5'h01;
            // at most 24 octets a message
            if (scr_last) tx_r <= TX_IDLE;
            else if (scnt_r == 5'(oct_pkg::SCR_MAX - 1)) tx_r <= TX_SCODE;
          end
        end
        default: tx_r <= TX_IDLE;
      endcase
    end
  end
  // Registered octet output
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.d2p_data <= 8'h00;
      lnk.d2p_valid <= 1'b0;
      lnk.d2p_sof <= 1'b0;
      lnk.d2p_eof <= 1'b0;
      lnk.d2p_addr <= 8'h00;
    end else begin
      // Screen code octet leads every screen message, split ones too
      lnk.d2p_valid <= tx_r == TX_CODE || tx_r == TX_ARG || tx_r == TX_SCODE ||
                       (scr_ready && scr_valid);
      lnk.d2p_sof <= tx_r == TX_CODE || tx_r == TX_SCODE;
      lnk.d2p_eof <= tx_r == TX_ARG || (scr_ready && scr_valid &&
                     (scr_last || scnt_r == 5'(oct_pkg::SCR_MAX - 1)));
      lnk.d2p_addr <= reply_addr_r;
      if (tx_r == TX_CODE) lnk.d2p_data <= tcode_r;
      else if (tx_r == TX_SCODE) lnk.d2p_data <= oct_pkg::CODE_SCREEN;
      else if (tx_r == TX_ARG) lnk.d2p_data <= tcode_r == oct_pkg::CODE_MAINT_STAT ? mstat : targ_r;
      else lnk.d2p_data <= scr_data;
    end
  end
endmodule // oct_dev

// [logic/oct_peer.sv]
`timescale 1ns/1ps
module oct_peer #(
  parameter oct_pkg::oct_role_e ROLE = oct_pkg::OCT_CUST_END
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // User orders: connect, disconnect and loop requests are one-cycle pulses
  input wire logic connect_req,
  input wire logic disconnect_req,
  input wire logic loop_req,
  input wire logic sys_loop,
  input wire logic [7:0] loop_dest,
  input wire logic [87:0] loop_cmds,
  input wire logic net_end_online,
  input wire logic [7:0] key_data,
  input wire logic key_valid,
  // User status
  output logic key_ready,
  output logic connected,
  output logic refused,
  output logic [7:0] scr_data,
  output logic scr_valid,
  output logic [7:0] mstat,
  output logic mstat_valid,
  output logic busy,
  oct_link_if.peer lnk
);
  // ----------------------------------------------------------------
  // Receive answers
  // ----------------------------------------------------------------
  logic [7:0] rcode_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rcode_r <= 8'h00;
      connected <= 1'b0;
      refused <= 1'b0;
      scr_data <= 8'h00;
      scr_valid <= 1'b0;
      mstat <= 8'h00;
      mstat_valid <= 1'b0;
    end else begin
      scr_valid <= 1'b0;
      mstat_valid <= 1'b0;
      refused <= 1'b0;
      if (disconnect_req) connected <= 1'b0;
      if (lnk.d2p_valid) begin
        if (lnk.d2p_sof) rcode_r <= lnk.d2p_data;
        else if (rcode_r == oct_pkg::CODE_CONN_RESP) begin
          connected <= lnk.d2p_data == oct_pkg::STAT_CONNECTED;
          refused <= lnk.d2p_data != oct_pkg::STAT_CONNECTED;
        end else if (rcode_r == oct_pkg::CODE_SCREEN && connected) begin
          scr_data <= lnk.d2p_data;
          scr_valid <= 1'b1;
        end else if (rcode_r == oct_pkg::CODE_MAINT_STAT) begin
          mstat <= lnk.d2p_data & 8'h7f;
          mstat_valid <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Transmit orders
  // ----------------------------------------------------------------
  logic [3:0] tidx_r;
  logic [3:0] tlen_r;
  logic [95:0] tbuf_r;
  logic kbd_r;
  assign key_ready = connected && !busy && !disconnect_req;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      kbd_r <= 1'b0;
      tidx_r <= 4'h0;
      tlen_r <= 4'h0;
      tbuf_r <= 96'h0;
      lnk.p2d_data <= 8'h00;
      lnk.p2d_valid <= 1'b0;
      lnk.p2d_sof <= 1'b0;
      lnk.p2d_eof <= 1'b0;
      lnk.p2d_addr <= 8'h00;
    end else begin
      lnk.p2d_valid <= 1'b0;
      lnk.p2d_sof <= 1'b0;
      lnk.p2d_eof <= 1'b0;
      if (!busy) begin
        if (connect_req || disconnect_req) begin
          lnk.p2d_valid <= 1'b1;
          lnk.p2d_sof <= 1'b1;
          lnk.p2d_eof <= 1'b1;
          lnk.p2d_addr <= loop_dest;
          lnk.p2d_data <= connect_req ? oct_pkg::CODE_CONNECT : oct_pkg::CODE_DISCONNECT;
        end else if (loop_req && !(sys_loop && ROLE == oct_pkg::OCT_CUST_END &&
                     !net_end_online)) begin
          busy <= 1'b1;
          tidx_r <= 4'h1;
          tbuf_r <= {sys_loop ? oct_pkg::CODE_SYS_LOOP : oct_pkg::CODE_ELEM_LOOP, loop_cmds};
          tlen_r <= sys_loop ? 4'(oct_pkg::SYS_LEN) : 4'h2;
          lnk.p2d_addr <= !sys_loop ? loop_dest : (ROLE == oct_pkg::OCT_NET_END ?
                          oct_pkg::ADDR_BROADCAST : oct_pkg::ADDR_NET_END);
          lnk.p2d_valid <= 1'b1;
          lnk.p2d_sof <= 1'b1;
          lnk.p2d_data <= sys_loop ? oct_pkg::CODE_SYS_LOOP : oct_pkg::CODE_ELEM_LOOP;
          kbd_r <= 1'b0;
        end else if (key_valid && connected) begin
          busy <= 1'b1;
          kbd_r <= 1'b1;
          tidx_r <= 4'h1;
          tbuf_r <= {oct_pkg::CODE_KEYBOARD, key_data, 80'h0}; // one key a message
          tlen_r <= 4'h2;
          lnk.p2d_addr <= loop_dest;
          lnk.p2d_valid <= 1'b1;
          lnk.p2d_sof <= 1'b1;
          lnk.p2d_data <= oct_pkg::CODE_KEYBOARD;
        end
      end else begin
        lnk.p2d_valid <= 1'b1;
        // Elem loop payload sits in the low octet of loop_cmds
        lnk.p2d_data <= (!kbd_r && tlen_r == 4'h2) ? tbuf_r[7:0] : tbuf_r[87 - 8 * (tidx_r - 1) -: 8];
        lnk.p2d_eof <= tidx_r == tlen_r - 4'h1;
        tidx_r <= tidx_r + 4'h1;
        if (tidx_r == tlen_r - 4'h1) busy <= 1'b0;
      end
    end
  end
endmodule // oct_peer

// [tb/oct_link_assertions.sv]
`timescale 1ns/1ps
module oct_link_assertions #(
  parameter logic [7:0] OWN_ADDR = 8'h01
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Device to peer
  input wire logic [7:0] d2p_data,
  input wire logic d2p_valid,
  input wire logic d2p_sof,
  input wire logic d2p_eof,
  input wire logic [7:0] d2p_addr,
  // Peer to device
  input wire logic [7:0] p2d_data,
  input wire logic p2d_valid,
  input wire logic p2d_sof,
  input wire logic p2d_eof,
  input wire logic [7:0] p2d_addr
);
  // ----------------------------------------------------------------
  // Message tracking
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [7:0] p_cnt_r, d_cnt_r, p_code_r, d_code_r;
  logic conn_seen_r;
  wire logic [7:0] p_len = p2d_sof ? 8'h01 : p_cnt_r + 8'h01;
  wire logic [7:0] d_len = d2p_sof ? 8'h01 : d_cnt_r + 8'h01;
  wire logic [7:0] p_code = p2d_sof ? p2d_data : p_code_r;
  wire logic [7:0] d_code = d2p_sof ? d2p_data : d_code_r;
  wire logic p_mine = (p2d_addr == OWN_ADDR) || (p2d_addr == oct_pkg::ADDR_BROADCAST);
  // Octet position and code of the message in flight, per direction
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      p_cnt_r <= 8'h00;
      p_code_r <= 8'h00;
    end else if (p2d_valid) begin
      p_cnt_r <= p_len;
      p_code_r <= p_code;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      d_cnt_r <= 8'h00;
      d_code_r <= 8'h00;
    end else if (d2p_valid) begin
      d_cnt_r <= d_len;
      d_code_r <= d_code;
    end
  end
  // Session as seen on the wire; a timeout is invisible here, so only disconnect clears
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conn_seen_r <= 1'b0;
    end else if (p2d_valid && p2d_sof && p2d_data == oct_pkg::CODE_DISCONNECT) begin
      conn_seen_r <= 1'b0;
    end else if (d2p_valid && d2p_eof && d_code == oct_pkg::CODE_CONN_RESP &&
                 d2p_data == oct_pkg::STAT_CONNECTED) begin
      conn_seen_r <= 1'b1;
    end
  end
  sequence s_conn_req;
    p2d_valid && p2d_sof && p2d_eof && p2d_data == oct_pkg::CODE_CONNECT && p_mine;
  endsequence
  sequence s_conn_resp;
    d2p_valid && d2p_sof && d2p_data == oct_pkg::CODE_CONN_RESP ##1 d2p_valid && d2p_eof;
  endsequence
  sequence s_elem_req;
    p2d_valid && p2d_sof && p2d_data == oct_pkg::CODE_ELEM_LOOP && p2d_addr == OWN_ADDR
    ##1 p2d_valid && p2d_eof;
  endsequence
  sequence s_mstat;
    d2p_valid && d2p_sof && d2p_data == oct_pkg::CODE_MAINT_STAT
    ##1 d2p_valid && d2p_eof && !d2p_data[7] && !d2p_data[5];
  endsequence
  chk_conn_answer: assert property (s_conn_req |-> ##2 s_conn_resp)
    else $error("connect request not answered on time");
  chk_conn_status: assert property (d2p_valid && d2p_sof && d2p_data == oct_pkg::CODE_CONN_RESP
    |=> d2p_eof && d2p_data inside {8'h00, 8'h01})
    else $error("connect response status malformed");
  chk_screen_follows: assert property (d2p_valid && d2p_eof && d_code == oct_pkg::CODE_CONN_RESP
    && d2p_data == oct_pkg::STAT_CONNECTED
    |-> ##[1:40] d2p_valid && d2p_sof && d2p_data == oct_pkg::CODE_SCREEN)
    else $error("no screen after connected response");
  chk_elem_reply: assert property (s_elem_req |-> ##2 s_mstat)
    else $error("element loopback not answered with status");
  chk_sys_reply: assert property (p2d_valid && p2d_eof && p_code == oct_pkg::CODE_SYS_LOOP
    && p2d_addr == OWN_ADDR |-> ##2 s_mstat)
    else $error("system loopback not answered with status");
  chk_sys_dest: assert property (p2d_valid && p2d_sof && p2d_data == oct_pkg::CODE_SYS_LOOP
    |-> p2d_addr == oct_pkg::ADDR_NET_END)
    else $error("system loopback from customer end misaddressed");
  chk_kbd_length: assert property (p2d_valid && p2d_eof && p_code == oct_pkg::CODE_KEYBOARD
    |-> p_len inside {[8'd2:8'd9]})
    else $error("keyboard message length out of range");
  chk_scr_length: assert property (d2p_valid && d2p_eof && d_code == oct_pkg::CODE_SCREEN
    |-> d_len inside {[8'd2:8'd25]})
    else $error("screen message length out of range");
  chk_kbd_session: assert property (p2d_valid && p2d_sof && p2d_data == oct_pkg::CODE_KEYBOARD
    |-> conn_seen_r)
    else $error("keyboard sent before connected");
endmodule // oct_link_assertions

// [tb/tb_ops_channel_terminal_and_loopback.sv]
`timescale 1ns/1ps
module tb_ops_channel_terminal_and_loopback;
  // ----------------------------------------------------------------
  // Stimulus, monitors and tests
  // ----------------------------------------------------------------
  localparam int TMO = 50;
  localparam int SCR_N = 5;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic term_support = 1'b0;
  logic local_pwr = 1'b1;
  logic [2:0] straps = 3'b001;
  logic net_online = 1'b1;
  logic scr_hold = 1'b0;
  logic [4:0] scr_idx = 5'h00;
  logic connect_req = 1'b0;
  logic disconnect_req = 1'b0;
  logic loop_req = 1'b0;
  logic sys_loop = 1'b0;
  logic [87:0] loop_cmds = 88'h0;
  logic [7:0] key_data = 8'h00;
  logic key_valid = 1'b0;
  logic scr_ready, scr_first, session_open, loop_net, loop_cust, loop_special, kbd_valid;
  logic key_ready, connected, refused, pscr_valid, mstat_valid, busy;
  logic [7:0] kbd_data, pscr_data, mstat;
  logic [7:0] scr_q[$], kbd_q[$], mstat_q[$];
  logic exp_net = 1'b0;
  logic exp_cust = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  int first_cnt = 0;
  int refused_cnt = 0;
  oct_link_if lnk();
  oct_dev #(.ROLE(oct_pkg::OCT_NET_END), .SESSIONS(1), .TIMEOUT_CYC(TMO)) u_oct_dev (
    .mclk(mclk), .arst_n(arst_n), .own_addr(oct_pkg::ADDR_NET_END), .local_pwr(local_pwr),
    .cust_rev(straps[1]), .net_rev(straps[0]), .prop_state(straps[2]),
    .net_end_online(net_online), .term_support(term_support),
    .scr_data(8'h41 + {3'h0, scr_idx}), .scr_valid(scr_ready || scr_hold),
    .scr_last(scr_idx == 5'(SCR_N - 1)), .scr_ready(scr_ready), .scr_first(scr_first),
    .kbd_data(kbd_data), .kbd_valid(kbd_valid), .session_open(session_open),
    .loop_net(loop_net), .loop_cust(loop_cust), .loop_special(loop_special), .lnk(lnk.dev));
  oct_peer #(.ROLE(oct_pkg::OCT_CUST_END)) u_oct_peer (
    .mclk(mclk), .arst_n(arst_n), .connect_req(connect_req), .disconnect_req(disconnect_req),
    .loop_req(loop_req), .sys_loop(sys_loop), .loop_dest(oct_pkg::ADDR_NET_END),
    .loop_cmds(loop_cmds), .net_end_online(net_online), .key_data(key_data),
    .key_valid(key_valid), .key_ready(key_ready), .connected(connected), .refused(refused),
    .scr_data(pscr_data), .scr_valid(pscr_valid), .mstat(mstat), .mstat_valid(mstat_valid),
    .busy(busy), .lnk(lnk.peer));
  oct_link_assertions #(.OWN_ADDR(oct_pkg::ADDR_NET_END)) u_oct_link_assertions (
    .mclk(mclk), .arst_n(arst_n), .d2p_data(lnk.d2p_data), .d2p_valid(lnk.d2p_valid),
    .d2p_sof(lnk.d2p_sof), .d2p_eof(lnk.d2p_eof), .d2p_addr(lnk.d2p_addr),
    .p2d_data(lnk.p2d_data), .p2d_valid(lnk.p2d_valid), .p2d_sof(lnk.p2d_sof),
    .p2d_eof(lnk.p2d_eof), .p2d_addr(lnk.p2d_addr));
  // Clock, reset held for 16 cycles
  always #12.5 mclk = ~mclk;
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
  end
  // Screen source walks a fixed text, restarting after its last octet
  always @(posedge mclk) begin
    if (scr_ready) scr_idx <= (scr_idx == 5'(SCR_N - 1)) ? 5'h00 : scr_idx + 5'h01;
  end
  // Collect the one-cycle pulses so no result is missed
  always @(posedge mclk) begin
    if (pscr_valid === 1'b1) scr_q.push_back(pscr_data);
    if (kbd_valid === 1'b1) kbd_q.push_back(kbd_data);
    if (mstat_valid === 1'b1) mstat_q.push_back(mstat);
    if (scr_first === 1'b1) first_cnt++;
    if (refused === 1'b1) refused_cnt++;
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Idle means both directions silent and the peer not busy for 8 cycles
  task automatic wait_quiet;
    int q;
    int n;
    q = 0;
    n = 0;
    while (q < 8 && n < 400) begin
      @(posedge mclk);
      n++;
      q = (lnk.d2p_valid === 1'b0 && lnk.p2d_valid === 1'b0 && busy === 1'b0) ? q + 1 : 0;
    end
    if (n >= 400) check8(8'h00, 8'h01);
  endtask
  // One-cycle order pulse: 0 connect, 1 disconnect, 2 loopback
  task automatic go(input int k);
    @(posedge mclk);
    connect_req <= (k == 0);
    disconnect_req <= (k == 1);
    loop_req <= (k == 2);
    @(posedge mclk);
    connect_req <= 1'b0;
    disconnect_req <= 1'b0;
    loop_req <= 1'b0;
    wait_quiet();
  endtask
  // Loopback order and check of the single status reply
  task automatic loop(input logic sys, input logic [87:0] cmds, input logic [7:0] own);
    sys_loop <= sys;
    loop_cmds <= cmds;
    mstat_q.delete();
    go(2);
    if (own[6]) {exp_net, exp_cust} = 2'b00;
    if (own[3]) exp_net = 1'b1;
    if (own[2]) exp_cust = 1'b1;
    if (own[1]) exp_net = 1'b0;
    if (own[0]) exp_cust = 1'b0;
    check8(8'(mstat_q.size()), 8'h01);
    check8(mstat_q[0], {1'b0, straps[2], 1'b0, exp_cust, exp_net, local_pwr, straps[1:0]});
    check8({5'h0, loop_net, loop_cust, loop_special}, {5'h0, exp_net, exp_cust, 1'b0});
  endtask
  task automatic screen_check;
    check8(8'(scr_q.size()), 8'(SCR_N));
    foreach (scr_q[i]) check8(scr_q[i], 8'h41 + 8'(i));
    scr_q.delete();
  endtask
  // Each command bit alone except special off, a pair, a poll, a reserved bit and a clear
  logic [7:0] cmd_tab[10] = '{8'h08, 8'h04, 8'h00, 8'h20, 8'h02, 8'h80, 8'h0c, 8'h40,
    8'h04, 8'h01};
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
  initial begin
    @(posedge arst_n);
    check8({5'h0, session_open, loop_net, loop_cust}, 8'h00);
    go(0);
    check8(8'(refused_cnt), 8'h01);
    check8({7'h0, connected}, 8'h00);
    term_support <= 1'b1;
    go(0);
    check8({6'h0, connected, session_open}, 8'h03);
    check8(8'(first_cnt), 8'h01);
    screen_check();
    scr_hold <= 1'b1;
    @(posedge mclk);
    scr_hold <= 1'b0;
    wait_quiet();
    screen_check();
    // Nine keys, sent by the peer one to a message
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk);
      key_data <= 8'h61 + 8'(i);
      key_valid <= 1'b1;
      do @(negedge mclk); while (key_ready !== 1'b1);
      @(posedge mclk);
      key_valid <= 1'b0;
    end
    wait_quiet();
    check8(8'(kbd_q.size()), 8'h09);
    foreach (kbd_q[i]) check8(kbd_q[i], 8'h61 + 8'(i));
    go(0);
    check8(8'(first_cnt), 8'h01);
    screen_check();
    go(1);
    check8({6'h0, connected, session_open}, 8'h00);
    foreach (cmd_tab[i]) loop(1'b0, {80'h0, cmd_tab[i]}, cmd_tab[i]);
    local_pwr <= 1'b0;
    straps <= 3'b110;
    loop(1'b0, 88'h0, 8'h00);
    loop(1'b1, {8'h08, 8'h04, {8{8'h05}}, 8'h00}, 8'h08);
    loop(1'b1, {8'hc2, 8'h08, {8{8'h08}}, 8'h00}, 8'hc2);
    net_online <= 1'b0;
    mstat_q.delete();
    go(2);
    check8(8'(mstat_q.size()), 8'h00);
    net_online <= 1'b1;
    go(0);
    check8({7'h0, session_open}, 8'h01);
    repeat (TMO + 20) @(posedge mclk);
    check8({7'h0, session_open}, 8'h00);
    report_and_stop();
  end
endmodule // tb_ops_channel_terminal_and_loopback
